// ===== common/uia_regs.svh
// Purpose: Offsets, field positions, reset values and sizes of the user input block
// Assumes: Word addressed register port, one register per address
// Notes:   Included by its bare name
//
// Overview of operation
// - Closed-or-virtual-off mode asserts when contact closed or virtual input off.
// - Open-or-virtual-on mode asserts when contact open or virtual input on.
// - Open-or-virtual-off mode asserts when contact open or virtual input off.
// - Closed-xor-virtual-on asserts when exactly one of closed, virtual on holds.
// - Closed-xor-virtual-off asserts when exactly one of closed, virtual off holds.
// - Open-xor-virtual-on asserts when exactly one of open, virtual on holds.
// - Open-xor-virtual-off asserts when exactly one of open, virtual off holds.
// - Asserted alarm shows its message, label choice, and drives auxiliary relay 3 and LED.
// - Alarm deassert removes message and relay 3 drive without any reset.
// - Every assertion logs an event naming the invoked function.
// - Control type drives relay 3 like alarm, but no message and no alarm LED.
// - Trip type drives trip relay 1 and LED plus relay 3 and LED.
// - Trip message and trip status LED stay latched until a reset command given while the trip is deasserted.
// - Virtual-only functions 15 to 20 support virtual on and virtual off modes.
// - Pure virtual modes ignore the contact input entirely.
`ifndef UIA_REGS_SVH
`define UIA_REGS_SVH

`define UIA_NUM_FUNC       20
`define UIA_NUM_CONTACT    14

`define UIA_CFG_BASE       8'h00
`define UIA_CFG_LAST       8'h13
`define UIA_VIRT_OFS       8'h20
`define UIA_CMD_OFS        8'h21
`define UIA_STAT_OFS       8'h22
`define UIA_LATCH_OFS      8'h23
`define UIA_CONT_OFS       8'h24

`define UIA_CFG_MODE_LSB   0
`define UIA_CFG_MODE_MSB   3
`define UIA_CFG_KIND_LSB   4
`define UIA_CFG_KIND_MSB   5
`define UIA_CFG_NAME_BIT   6
`define UIA_CFG_MSB        6
`define UIA_CMD_RESET_BIT  0

`define UIA_CFG_RST        7'h00
`define UIA_VIRT_RST       20'h00000
`define UIA_CONT_RST       14'h0000

`endif

// ===== common/uia_pkg.sv
// Purpose: Types of the user input block
// Assumes: Used with package scope, never imported
// Notes:   Mode code 4'b1111 is illegal and never asserts
package uia_pkg;

   typedef enum logic [3:0]
   {
      MODE_OFF          = 4'b0000,
      MODE_V_ON         = 4'b0001,
      MODE_V_OFF        = 4'b0010,
      MODE_CLOSED_A_VON = 4'b0011,
      MODE_CLOSED_A_VOF = 4'b0100,
      MODE_OPEN_A_VON   = 4'b0101,
      MODE_OPEN_A_VOF   = 4'b0110,
      MODE_CLOSED_O_VON = 4'b0111,
      MODE_CLOSED_O_VOF = 4'b1000,
      MODE_OPEN_O_VON   = 4'b1001,
      MODE_OPEN_O_VOF   = 4'b1010,
      MODE_CLOSED_X_VON = 4'b1011,
      MODE_CLOSED_X_VOF = 4'b1100,
      MODE_OPEN_X_VON   = 4'b1101,
      MODE_OPEN_X_VOF   = 4'b1110
   } uia_mode_t;

   typedef enum logic [1:0]
   {
      KIND_OFF     = 2'b00,
      KIND_ALARM   = 2'b01,
      KIND_CONTROL = 2'b10,
      KIND_TRIP    = 2'b11
   } uia_kind_t;

endpackage

// ===== verilog/uia_top.sv
// Purpose: Assertion logic of the programmable user inputs
// Assumes: Contacts come from pins; register port on the system clock
// Notes:   Functions 15 to 20 have no contact and accept virtual modes only
`timescale 1ns/1ps
`include "uia_regs.svh"

module uia_top
(
   input  wire logic                          i_clk_sys,
   input  wire logic                          i_sys_rst,
   input  wire logic [`UIA_NUM_CONTACT-1:0]   i_contact_closed,
   input  wire logic [7:0]                    i_addr,
   input  wire logic [31:0]                   i_wdata,
   input  wire logic                          i_wr,
   input  wire logic                          i_rd,
   output logic      [31:0]                   o_rdata,
   output logic                               o_aux3_relay,
   output logic                               o_aux3_led,
   output logic                               o_alarm_led,
   output logic                               o_trip1_relay,
   output logic                               o_trip1_led,
   output logic                               o_trip_status_led,
   output logic      [`UIA_NUM_FUNC-1:0]      o_diag_msg,
   output logic      [`UIA_NUM_FUNC-1:0]      o_diag_custom,
   output logic                               o_event_valid,
   output logic      [4:0]                    o_event_id
);

   // Combining logic of one function
   function automatic logic uia_eval
   (
      input uia_pkg::uia_mode_t mode,
      input logic               closed,
      input logic               von,
      input logic               has_contact
   );
      logic r;
      r = 1'b0;
      unique case (mode)
         uia_pkg::MODE_OFF:          r = 1'b0;
         uia_pkg::MODE_V_ON:         r = von;
         uia_pkg::MODE_V_OFF:        r = !von;
         uia_pkg::MODE_CLOSED_A_VON: r = has_contact && closed && von;
         uia_pkg::MODE_CLOSED_A_VOF: r = has_contact && closed && !von;
         uia_pkg::MODE_OPEN_A_VON:   r = has_contact && !closed && von;
         uia_pkg::MODE_OPEN_A_VOF:   r = has_contact && !closed && !von;
         uia_pkg::MODE_CLOSED_O_VON: r = has_contact && (closed || von);
         uia_pkg::MODE_CLOSED_O_VOF: r = has_contact && (closed || !von);
         uia_pkg::MODE_OPEN_O_VON:   r = has_contact && (!closed || von);
         uia_pkg::MODE_OPEN_O_VOF:   r = has_contact && (!closed || !von);
         uia_pkg::MODE_CLOSED_X_VON: r = has_contact && (closed ^ von);
         uia_pkg::MODE_CLOSED_X_VOF: r = has_contact && (closed ^ !von);
         uia_pkg::MODE_OPEN_X_VON:   r = has_contact && (!closed ^ von);
         uia_pkg::MODE_OPEN_X_VOF:   r = has_contact && (!closed ^ !von);
         default:                    r = 1'b0;
      endcase
      return r;
   endfunction

   // Configuration address decode
   function automatic logic uia_cfg_hit
   (
      input logic [7:0] addr
   );
      return (addr >= `UIA_CFG_BASE) && (addr <= `UIA_CFG_LAST);
   endfunction

   // Contact synchroniser and filter
   logic [`UIA_NUM_CONTACT-1:0] sync1;
   logic [`UIA_NUM_CONTACT-1:0] sync2;
   logic [`UIA_NUM_CONTACT-1:0] sync3;
   logic [`UIA_NUM_CONTACT-1:0] contact;
   logic [`UIA_NUM_CONTACT-1:0] next_sync1;
   logic [`UIA_NUM_CONTACT-1:0] next_sync2;
   logic [`UIA_NUM_CONTACT-1:0] next_sync3;
   logic [`UIA_NUM_CONTACT-1:0] next_contact;
   logic [`UIA_NUM_CONTACT-1:0] agree;

   always_comb
   begin
      next_sync1   = i_contact_closed;
      next_sync2   = sync1;
      next_sync3   = sync2;
      agree        = ~(sync2 ^ sync3);
      next_contact = (sync3 & agree) | (contact & ~agree);
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         sync1   <= `UIA_CONT_RST;
         sync2   <= `UIA_CONT_RST;
         sync3   <= `UIA_CONT_RST;
         contact <= `UIA_CONT_RST;
      end
      else
      begin
         sync1   <= next_sync1;
         sync2   <= next_sync2;
         sync3   <= next_sync3;
         contact <= next_contact;
      end
   end

   // Software registers
   logic [`UIA_CFG_MSB:0]    cfg      [0:`UIA_NUM_FUNC-1];
   logic [`UIA_CFG_MSB:0]    next_cfg [0:`UIA_NUM_FUNC-1];
   logic [`UIA_NUM_FUNC-1:0] virt;
   logic [`UIA_NUM_FUNC-1:0] next_virt;
   logic                     reset_cmd;

   always_comb
   begin
      for (int i = 0; i < `UIA_NUM_FUNC; i++)
      begin
         next_cfg[i] = cfg[i];
      end
      next_virt = virt;
      reset_cmd = 1'b0;
      if (i_wr)
      begin
         if (uia_cfg_hit(i_addr))
         begin
            next_cfg[i_addr[4:0]] = i_wdata[`UIA_CFG_MSB:0];
         end
         if (i_addr == `UIA_VIRT_OFS)
         begin
            next_virt = i_wdata[`UIA_NUM_FUNC-1:0];
         end
         if (i_addr == `UIA_CMD_OFS)
         begin
            reset_cmd = i_wdata[`UIA_CMD_RESET_BIT];
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         for (int i = 0; i < `UIA_NUM_FUNC; i++)
         begin
            cfg[i] <= `UIA_CFG_RST;
         end
         virt <= `UIA_VIRT_RST;
      end
      else
      begin
         for (int i = 0; i < `UIA_NUM_FUNC; i++)
         begin
            cfg[i] <= next_cfg[i];
         end
         virt <= next_virt;
      end
   end

   // Per function evaluation
   logic [`UIA_NUM_FUNC-1:0] closed_vec;
   logic [`UIA_NUM_FUNC-1:0] is_alarm;
   logic [`UIA_NUM_FUNC-1:0] is_trip;
   logic [`UIA_NUM_FUNC-1:0] name_set;
   logic [`UIA_NUM_FUNC-1:0] asserted;
   logic [`UIA_NUM_FUNC-1:0] latch;
   logic [`UIA_NUM_FUNC-1:0] pend;
   logic [`UIA_NUM_FUNC-1:0] next_asserted;
   logic [`UIA_NUM_FUNC-1:0] next_latch;
   logic [`UIA_NUM_FUNC-1:0] next_pend;
   logic [`UIA_NUM_FUNC-1:0] grant;
   logic [4:0]               grant_id;
   logic                     next_ev_valid;
   logic [4:0]               next_ev_id;
   logic                     next_aux3;
   logic                     next_alarm_led;
   logic                     next_trip1;
   logic                     next_trip_stat;
   logic [`UIA_NUM_FUNC-1:0] next_diag;
   logic [`UIA_NUM_FUNC-1:0] next_custom;
   uia_pkg::uia_mode_t       mode;
   uia_pkg::uia_kind_t       kind;
   logic                     has_contact;

   always_comb
   begin
      mode        = uia_pkg::MODE_OFF;
      kind        = uia_pkg::KIND_OFF;
      has_contact = 1'b0;
      closed_vec  = {{(`UIA_NUM_FUNC-`UIA_NUM_CONTACT){1'b0}}, contact};
      for (int i = 0; i < `UIA_NUM_FUNC; i++)
      begin
         mode = uia_pkg::uia_mode_t'(cfg[i][`UIA_CFG_MODE_MSB:`UIA_CFG_MODE_LSB]);
         kind = uia_pkg::uia_kind_t'(cfg[i][`UIA_CFG_KIND_MSB:`UIA_CFG_KIND_LSB]);
         has_contact = (i < `UIA_NUM_CONTACT);
         is_alarm[i] = (kind == uia_pkg::KIND_ALARM);
         is_trip[i]  = (kind == uia_pkg::KIND_TRIP);
         name_set[i] = cfg[i][`UIA_CFG_NAME_BIT];
         next_asserted[i] = (kind != uia_pkg::KIND_OFF)
                            && uia_eval(mode, closed_vec[i], virt[i], has_contact);
      end
      // Trip latch, a trip already registered as asserted wins over the reset command
      next_latch = (latch & ~{`UIA_NUM_FUNC{reset_cmd}}) | (asserted & is_trip);
      // Event queue, lowest number first
      grant    = '0;
      grant_id = 5'h00;
      for (int i = `UIA_NUM_FUNC - 1; i >= 0; i--)
      begin
         if (pend[i])
         begin
            grant    = '0;
            grant[i] = 1'b1;
            grant_id = 5'(i);
         end
      end
      next_pend     = (pend & ~grant) | (next_asserted & ~asserted);
      next_ev_valid = |pend;
      next_ev_id    = grant_id;
      next_aux3      = |asserted;
      next_alarm_led = |(asserted & is_alarm);
      next_trip1     = |(asserted & is_trip);
      next_trip_stat = |next_latch;
      next_diag      = (asserted & is_alarm) | next_latch;
      next_custom    = next_diag & name_set;
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         asserted          <= '0;
         latch             <= '0;
         pend              <= '0;
         o_event_valid     <= 1'b0;
         o_event_id        <= 5'h00;
         o_aux3_relay      <= 1'b0;
         o_aux3_led        <= 1'b0;
         o_alarm_led       <= 1'b0;
         o_trip1_relay     <= 1'b0;
         o_trip1_led       <= 1'b0;
         o_trip_status_led <= 1'b0;
         o_diag_msg        <= '0;
         o_diag_custom     <= '0;
      end
      else
      begin
         asserted          <= next_asserted;
         latch             <= next_latch;
         pend              <= next_pend;
         o_event_valid     <= next_ev_valid;
         o_event_id        <= next_ev_id;
         o_aux3_relay      <= next_aux3;
         o_aux3_led        <= next_aux3;
         o_alarm_led       <= next_alarm_led;
         o_trip1_relay     <= next_trip1;
         o_trip1_led       <= next_trip1;
         o_trip_status_led <= next_trip_stat;
         o_diag_msg        <= next_diag;
         o_diag_custom     <= next_custom;
      end
   end

   // Read port, one cycle latency
   logic [31:0] next_rdata;

   always_comb
   begin
      next_rdata = 32'h00000000;
      if (i_rd)
      begin
         if (uia_cfg_hit(i_addr))
         begin
            next_rdata = {25'h0000000, cfg[i_addr[4:0]]};
         end
         else if (i_addr == `UIA_VIRT_OFS)
         begin
            next_rdata = {12'h000, virt};
         end
         else if (i_addr == `UIA_STAT_OFS)
         begin
            next_rdata = {12'h000, asserted};
         end
         else if (i_addr == `UIA_LATCH_OFS)
         begin
            next_rdata = {12'h000, latch};
         end
         else if (i_addr == `UIA_CONT_OFS)
         begin
            next_rdata = {18'h00000, contact};
         end
      end
   end

   always_ff @(posedge i_clk_sys)
   begin
      if (i_sys_rst)
      begin
         o_rdata <= 32'h00000000;
      end
      else
      begin
         o_rdata <= next_rdata;
      end
   end

endmodule

// ===== tb/uia_top_props.sv
// Purpose: Port checks of the user input block
// Assumes: Bound to uia_top, one clock domain
// Notes:   Sees top ports only
`timescale 1ns/1ps
`include "uia_regs.svh"
module uia_top_props
(
   input wire logic        i_clk_sys,
   input wire logic        i_sys_rst,
   input wire logic [13:0] i_contact_closed,
   input wire logic [7:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        o_aux3_relay,
   input wire logic        o_aux3_led,
   input wire logic        o_alarm_led,
   input wire logic        o_trip1_relay,
   input wire logic        o_trip1_led,
   input wire logic        o_trip_status_led,
   input wire logic [19:0] o_diag_msg,
   input wire logic [19:0] o_diag_custom,
   input wire logic        o_event_valid,
   input wire logic [4:0]  o_event_id
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (i_sys_rst);
   sequence clr_s;
      i_wr && i_addr == `UIA_CMD_OFS && i_wdata[0];
   endsequence
   sequence quiet_s;
      !o_trip1_relay [*3];
   endsequence
   aux_pair_a: assert property (o_aux3_led == o_aux3_relay)
      else $error("aux led differs from relay");
   trip_pair_a: assert property (o_trip1_led == o_trip1_relay)
      else $error("trip led differs from relay");
   trip_aux_a: assert property (o_trip1_relay |-> o_aux3_relay)
      else $error("trip without aux relay");
   alarm_aux_a: assert property (o_alarm_led |-> o_aux3_relay)
      else $error("alarm led without aux relay");
   custom_msg_a: assert property ((o_diag_custom & ~o_diag_msg) == 20'h0)
      else $error("custom label without message");
   event_rise_a: assert property ($rose(o_aux3_relay) |-> ##[0:20] o_event_valid)
      else $error("assertion without event");
   trip_latch_a: assert property (o_trip1_relay |-> o_trip_status_led)
      else $error("trip without status led");
   latch_hold_a: assert property ($fell(o_trip_status_led) && !$past(i_sys_rst)
      |-> $past(i_wr && i_addr == `UIA_CMD_OFS && i_wdata[`UIA_CMD_RESET_BIT]))
      else $error("trip status dropped without clear");
   latch_clear_a: assert property (clr_s ##1 quiet_s |-> !o_trip_status_led)
      else $error("trip status kept after clear");
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
      else $error("read data outside read cycle");
   reset_quiet_a: assert property ($past(i_sys_rst) |-> o_diag_msg == 20'h0
      && !(o_aux3_relay | o_alarm_led | o_trip_status_led | o_event_valid))
      else $error("outputs active after reset");
endmodule
bind uia_top uia_top_props i_props (.i_clk_sys, .i_sys_rst, .i_contact_closed, .i_addr,
   .i_wdata, .i_wr, .i_rd, .o_rdata, .o_aux3_relay, .o_aux3_led, .o_alarm_led,
   .o_trip1_relay, .o_trip1_led, .o_trip_status_led, .o_diag_msg, .o_diag_custom,
   .o_event_valid, .o_event_id);

// ===== tb/test_uia_top.sv
// Purpose: Self-checking bench of the user input block
// Assumes: Registers driven over the plain port
// Notes:   Mode sweep on functions 1 and 15, then control and trip
`timescale 1ns/1ps
`include "uia_regs.svh"
module test_uia_top;
   logic        i_clk_sys, i_sys_rst, i_wr, i_rd, c, v, p, e, cu, h;
   logic [13:0] i_contact_closed;
   logic [7:0]  i_addr;
   logic [31:0] i_wdata, o_rdata;
   logic        o_aux3_relay, o_aux3_led, o_alarm_led, o_trip1_relay, o_trip1_led;
   logic        o_trip_status_led, o_event_valid;
   logic [19:0] o_diag_msg, o_diag_custom;
   logic [4:0]  o_event_id;
   int          err_count = 0, comparisons = 0, cyc = 0, evn, f;
   uia_top i_dut (.i_clk_sys, .i_sys_rst, .i_contact_closed, .i_addr, .i_wdata, .i_wr,
      .i_rd, .o_rdata, .o_aux3_relay, .o_aux3_led, .o_alarm_led, .o_trip1_relay,
      .o_trip1_led, .o_trip_status_led, .o_diag_msg, .o_diag_custom, .o_event_valid,
      .o_event_id);
   initial
   begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   task automatic chk(input logic [31:0] s, input logic [31:0] x);
      comparisons++;
      if (s !== x)
      begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, s, x);
      end
   endtask
   task automatic end_sim;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge i_clk_sys)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         end_sim();
      end
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk_sys);
      i_wr    <= 1'b1;
      i_addr  <= a;
      i_wdata <= d;
      @(posedge i_clk_sys);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      @(posedge i_clk_sys);
      i_rd   <= 1'b1;
      i_addr <= a;
      @(posedge i_clk_sys);
      i_rd <= 1'b0;
      #1;
      chk(o_rdata, x);
   endtask
   task automatic settle;
      evn = 0;
      repeat (9)
      begin
         @(posedge i_clk_sys);
         #1;
         if (o_event_valid === 1'b1 && o_event_id === 5'(f))
            evn++;
      end
   endtask
   function automatic logic exp_a(input logic [3:0] m, input logic c, v, hc);
      if (!hc && m > 4'h2)
         return 1'b0;
      case (m)
         4'h1: return v;
         4'h2: return ~v;
         4'h3: return c & v;
         4'h4: return c & ~v;
         4'h5: return ~c & v;
         4'h6: return ~c & ~v;
         4'h7: return c | v;
         4'h8: return c | ~v;
         4'h9: return ~c | v;
         4'ha: return ~c | ~v;
         4'hb: return c ^ v;
         4'hc: return c ^ ~v;
         4'hd: return ~c ^ v;
         4'he: return ~c ^ ~v;
         default: return 1'b0;
      endcase
   endfunction
   initial
   begin
      i_sys_rst = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0;
      i_contact_closed = 14'h0;
      c = 1'b0;
      v = 1'b0;
      f = 0;
      void'($urandom(19835));
      repeat (16) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      #1;
      chk({o_aux3_relay, o_trip_status_led, o_diag_msg}, 32'h0);
      rd(`UIA_STAT_OFS, 32'h0);
      for (int j = 0; j < 2; j++)
      begin
         f = j * 14;
         for (int m = 0; m < 16; m++)
         begin
            cu = 1'($urandom);
            wr(8'(f), 32'({cu, 2'b01, 4'(m)}));
            settle();
            p = exp_a(4'(m), c, v, f < 14);
            for (int k = 0; k < 6; k++)
            begin
               c = (k < 4) ? k[1] : 1'($urandom);
               h = exp_a(4'(m), c, v, f < 14);
               v = (k < 4) ? k[0] ^ k[1] : 1'($urandom);
               e = exp_a(4'(m), c, v, f < 14);
               // Contact first, virtual input once the contact has settled
               @(posedge i_clk_sys);
               i_contact_closed <= {13'($urandom), c};
               settle();
               chk(evn, 32'(h & ~p));
               wr(`UIA_VIRT_OFS, 32'(v) << f);
               settle();
               chk(o_aux3_relay, e);
               chk(o_alarm_led, e);
               chk(o_diag_msg, 32'(e) << f);
               chk(o_diag_custom, 32'(e & cu) << f);
               chk(evn, 32'(e & ~h));
               rd(`UIA_STAT_OFS, 32'(e) << f);
               p = e;
            end
         end
      end
      f = 0;
      wr(8'h00, 32'h21);
      wr(`UIA_VIRT_OFS, 32'h1);
      settle();
      chk({o_aux3_relay, o_alarm_led, o_diag_msg[0], o_trip1_relay}, 32'h8);
      chk(evn, 32'h1);
      wr(`UIA_VIRT_OFS, 32'h0);
      wr(8'h00, 32'h31);
      wr(`UIA_VIRT_OFS, 32'h1);
      settle();
      chk({o_trip1_relay, o_trip1_led, o_aux3_relay}, 32'h7);
      wr(`UIA_CMD_OFS, 32'h1);
      settle();
      chk({o_trip_status_led, o_diag_msg[0]}, 32'h3);
      rd(`UIA_CMD_OFS, 32'h0);
      rd(8'h30, 32'h0);
      wr(`UIA_VIRT_OFS, 32'h0);
      settle();
      chk({o_trip1_relay, o_aux3_relay, o_trip_status_led}, 32'h1);
      rd(`UIA_LATCH_OFS, 32'h1);
      wr(`UIA_CMD_OFS, 32'h1);
      settle();
      chk({o_trip_status_led, o_diag_msg[0]}, 32'h0);
      end_sim();
   end
endmodule
